//--- verilog/bsi_pkg.sv
// Purpose: constants shared by the barometric sensor command port
// Assumes: 7-bit serial slave address, byte-wide commands
// Notes:   conversion times are plain defaults, not measured figures
package bsi_pkg;
  localparam logic [6:0]  BSI_SLAVE_ADDR   = 7'h76;
  localparam int          BSI_CAL_WORDS    = 7;
  localparam int          BSI_CAL_BITS     = 112;
  localparam int          BSI_RESULT_BITS  = 24;
  // command bytes and fields
  localparam logic [7:0]  BSI_CMD_RESULT   = 8'h00;
  localparam logic [3:0]  BSI_CMD_CAL_HI   = 4'hA;
  localparam logic [3:0]  BSI_CMD_CONV_HI  = 4'h4;
  localparam int          BSI_TYP_BIT      = 4;
  localparam int          BSI_ADDR_MSB     = 3;
  localparam int          BSI_ADDR_LSB     = 1;
  localparam logic [2:0]  BSI_RATIO_MAX    = 3'h5;
  // crc sits in bits 15..12 of word zero
  localparam int          BSI_CRC_MSB      = 15;
  localparam int          BSI_CRC_LSB      = 12;
  // conversion time for oversampling 256, doubled per step
  localparam int          BSI_CONV_BASE_NS = 600;
  localparam int          BSI_CLK_NS       = 8;
  localparam int          BSI_CONV_BASE_CYC =
    (BSI_CONV_BASE_NS + BSI_CLK_NS - 1) / BSI_CLK_NS;
  typedef enum logic [1:0] {
    BSI_LAST_NONE = 2'h0,
    BSI_LAST_CONV = 2'h1,
    BSI_LAST_CAL  = 2'h2
  } bsi_mode_t;
endpackage

//--- verilog/bsi_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: input is asynchronous to clk
// Notes:   first stage is read only by the second; resets to idle high
`timescale 1ns/100ps
module bsi_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,   // destination clock
  input  wire logic         rst_n, // active low async reset
  input  wire logic [W-1:0] d,     // asynchronous level
  output logic      [W-1:0] q      // synchronised level
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // bus lines rest high, so no false edge follows reset
      meta_r <= '1;
      q      <= '1;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

//--- verilog/bsi_conv.sv
// Purpose: conversion timer and sample source on the system clock
// Assumes: start is a one-cycle pulse; sample input is the adc value
// Notes:   a restart or a read while busy spoils the result
`timescale 1ns/100ps
module bsi_conv
  import bsi_pkg::*;
#(
  parameter int BASE_CYC = BSI_CONV_BASE_CYC
) (
  input  wire logic        clk,          // system clock
  input  wire logic        rst_n,        // active low reset
  input  wire logic        start,        // start pulse
  input  wire logic        sel_temp,     // 1 temperature, 0 pressure
  input  wire logic [2:0]  oversampling_ratio, // code 0..5
  input  wire logic        spoil,        // read seen while busy
  input  wire logic [23:0] raw_pressure_sample,    // adc pressure
  input  wire logic [23:0] raw_temperature_sample, // adc temperature
  output logic             busy,         // conversion running
  output logic             done,         // one-cycle end pulse
  output logic [23:0]      result        // converted sample
);
  if (BASE_CYC < 1) begin : g_base_chk
    $error("BASE_CYC must be at least 1");
  end
  localparam int CW = 32;
  logic [CW-1:0] cnt_r;
  logic          temp_r;
  logic          bad_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= '0;
      busy   <= 1'b0;
      done   <= 1'b0;
      temp_r <= 1'b0;
      bad_r  <= 1'b0;
      result <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        bad_r  <= busy;
        busy   <= 1'b1;
        temp_r <= sel_temp;
        cnt_r  <= CW'(BASE_CYC) << oversampling_ratio;
      end else if (busy) begin
        if (spoil)
          bad_r <= 1'b1;
        if (cnt_r <= CW'(1)) begin
          busy   <= 1'b0;
          done   <= 1'b1;
          result <= temp_r ? raw_temperature_sample : raw_pressure_sample;
          if (bad_r || spoil)
            result <= ~(temp_r ? raw_temperature_sample
                               : raw_pressure_sample);
        end
        cnt_r <= cnt_r - CW'(1);
      end
    end
  end
endmodule

//--- verilog/bsi_top.sv
// Purpose: serial command port of a barometric sensor
// Assumes: scl and sda oversampled on clk_sys; scl is much slower
// Notes:   bytes shifted on sampled scl edges and decoded, all on clk_sys
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////
module bsi_top
  import bsi_pkg::*;
#(
  parameter int          CONV_CYC = BSI_CONV_BASE_CYC,
  parameter logic [15:0] CAL_W0   = 16'h0000,
  parameter logic [15:0] CAL_W1   = 16'h0000,
  parameter logic [15:0] CAL_W2   = 16'h0000,
  parameter logic [15:0] CAL_W3   = 16'h0000,
  parameter logic [15:0] CAL_W4   = 16'h0000,
  parameter logic [15:0] CAL_W5   = 16'h0000,
  parameter logic [15:0] CAL_W6   = 16'h0000
) (
  input  wire logic        clk_sys,  // system clock
  input  wire logic        nrst,     // active low async reset
  input  wire logic        scl,      // serial clock, link clock
  input  wire logic        sda_i,    // serial data level
  output logic             sda_o,    // serial data drive value
  output logic             sda_oe,   // high while pulling sda
  input  wire logic [23:0] raw_pressure_sample,    // adc pressure
  input  wire logic [23:0] raw_temperature_sample, // adc temperature
  output logic             conv_busy // conversion running
);
  //////////////////////////////////////////////////////////////////////////
  // reset and calibration memory
  logic [1:0] rst_sr;
  logic       rst_n;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      rst_sr <= 2'h0;
    else
      rst_sr <= {rst_sr[0], 1'b1};
  end
  assign rst_n = rst_sr[1];

  logic [15:0] cal_mem [BSI_CAL_WORDS];
  assign cal_mem[1] = CAL_W1;
  assign cal_mem[2] = CAL_W2;
  assign cal_mem[3] = CAL_W3;
  assign cal_mem[4] = CAL_W4;
  assign cal_mem[5] = CAL_W5;
  assign cal_mem[6] = CAL_W6;

  // crc over the words with the crc field cleared and a zero eighth word
  function automatic logic [3:0] crc4(input logic [111:0] w);
    logic [15:0] rem;
    logic [7:0]  b;
    rem = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      b   = (i < 14) ? w[111-8*i -: 8] : 8'h00;
      rem = rem ^ {8'h00, b};
      for (int k = 0; k < 8; k++)
        rem = rem[15] ? ((rem << 1) ^ 16'h3000) : (rem << 1);
    end
    return rem[15:12];
  endfunction

  logic [111:0] cal_flat;
  assign cal_flat = {CAL_W0 & 16'h0FFF, CAL_W1, CAL_W2, CAL_W3,
                     CAL_W4, CAL_W5, CAL_W6};
  assign cal_mem[0] = {crc4(cal_flat), CAL_W0[11:0]};

  //////////////////////////////////////////////////////////////////////////
  // link pins: oversampled through two flops, then edge detected
  // start and stop are sda edges while scl high; sensed on clk_sys
  logic [1:0] pin_s;
  bsi_sync #(.W(2)) u_pin_sync (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .d     ({scl, sda_i}),
    .q     (pin_s)
  );
  logic scl_s, sda_s, sda_d_r, scl_d_r;
  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sda_d_r <= 1'b1;
      scl_d_r <= 1'b1;
    end else begin
      sda_d_r <= sda_s;
      scl_d_r <= scl_s;
    end
  end
  logic start_p, stop_p, rise_p, fall_p;
  assign start_p = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_p  = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign rise_p  = scl_s && !scl_d_r;
  assign fall_p  = !scl_s && scl_d_r;

  //////////////////////////////////////////////////////////////////////////
  // bus state machine on the system clock, driven by sampled scl edges
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_AACK = 6'b000100,
    ST_WCMD = 6'b001000,
    ST_TX   = 6'b010000,
    ST_MACK = 6'b100000
  } bsi_state_t;
  bsi_state_t st_r;
  logic [7:0]  sh_r;
  logic [3:0]  bit_r;
  logic        rd_r;
  logic [23:0] tx_r;
  logic [1:0]  byte_r;
  logic [1:0]  nbytes_r;
  logic        ack_pend_r;
  bsi_mode_t   mode_r;
  logic [2:0]  cal_addr_r;
  logic        res_valid_r;
  logic        conv_start_r;
  logic        conv_temp_r;
  logic [2:0]  conv_ratio_r;
  logic        spoil_r;
  logic        conv_done;
  logic [23:0] conv_result;
  logic        busy_w;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r       <= ST_IDLE;
      sh_r       <= 8'h00;
      bit_r      <= 4'h0;
      rd_r       <= 1'b0;
      tx_r       <= 24'h0000_00;
      byte_r     <= 2'h0;
      nbytes_r   <= 2'h0;
      ack_pend_r <= 1'b0;
      sda_o      <= 1'b0;
      sda_oe     <= 1'b0;
    end else if (stop_p) begin
      st_r   <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (start_p) begin
      // a cut frame must not leave an ack pending for the next one
      st_r       <= ST_ADDR;
      bit_r      <= 4'h0;
      ack_pend_r <= 1'b0;
      sda_oe     <= 1'b0;
    end else begin
      unique case (st_r)
        ST_IDLE: sda_oe <= 1'b0;
        ST_ADDR: begin
          if (rise_p) begin
            sh_r  <= {sh_r[6:0], sda_s};
            bit_r <= bit_r + 4'h1;
          end
          if (fall_p && bit_r == 4'h8) begin
            if (sh_r[7:1] == BSI_SLAVE_ADDR) begin
              rd_r   <= sh_r[0];
              sda_oe <= 1'b1;
              st_r   <= ST_AACK;
            end else begin
              st_r <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (fall_p) begin
            bit_r <= 4'h0;
            if (rd_r) begin
              st_r   <= ST_TX;
              byte_r <= 2'h0;
              if (mode_r == BSI_LAST_CAL) begin
                tx_r     <= {cal_mem[cal_addr_r], 8'h00};
                nbytes_r <= 2'h2;
              end else begin
                tx_r     <= (mode_r == BSI_LAST_CONV && res_valid_r &&
                             !busy_w) ? conv_result : 24'h0000_00;
                nbytes_r <= 2'h3;
              end
              sda_oe <= 1'b1;
              sda_o  <= 1'b0;
            end else begin
              sda_oe <= 1'b0;
              st_r   <= ST_WCMD;
            end
          end
        end
        ST_WCMD: begin
          if (rise_p) begin
            sh_r  <= {sh_r[6:0], sda_s};
            bit_r <= bit_r + 4'h1;
          end
          if (fall_p && bit_r == 4'h8) begin
            sda_oe     <= 1'b1;
            ack_pend_r <= 1'b1;
          end else if (fall_p && ack_pend_r) begin
            sda_oe     <= 1'b0;
            ack_pend_r <= 1'b0;
            bit_r      <= 4'h0;
          end
        end
        ST_TX: begin
          // msb first per byte
          // drive the next bit after each falling edge; keep line released
          // when the bit is one so the bus reads high
          sda_oe <= !tx_r[23];
          sda_o  <= 1'b0;
          if (fall_p) begin
            tx_r  <= {tx_r[22:0], 1'b0};
            bit_r <= bit_r + 4'h1;
            if (bit_r == 4'h7) begin
              st_r   <= ST_MACK;
              sda_oe <= 1'b0;
            end
          end
        end
        ST_MACK: begin
          sda_oe <= 1'b0;
          if (rise_p) begin
            if (sda_s || byte_r + 2'h1 == nbytes_r)
              st_r <= ST_IDLE;
            else begin
              byte_r <= byte_r + 2'h1;
              bit_r  <= 4'h0;
            end
          end
          if (fall_p && st_r == ST_MACK && bit_r == 4'h0)
            st_r <= ST_TX;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // command decode at the end of the command byte
  logic cmd_p;
  assign cmd_p = (st_r == ST_WCMD) && fall_p && bit_r == 4'h8;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_r       <= BSI_LAST_NONE;
      cal_addr_r   <= 3'h0;
      res_valid_r  <= 1'b0;
      conv_start_r <= 1'b0;
      conv_temp_r  <= 1'b0;
      conv_ratio_r <= 3'h0;
      spoil_r      <= 1'b0;
    end else begin
      conv_start_r <= 1'b0;
      spoil_r      <= 1'b0;
      if (st_r == ST_AACK && fall_p && rd_r && mode_r == BSI_LAST_CONV)
        res_valid_r <= 1'b0;
      // end of conversion wins over a read clear in the same cycle
      if (conv_done)
        res_valid_r <= 1'b1;
      if (cmd_p) begin
        if (sh_r[7:4] == BSI_CMD_CAL_HI && !sh_r[0]) begin
          mode_r     <= BSI_LAST_CAL;
          cal_addr_r <= (sh_r[BSI_ADDR_MSB:BSI_ADDR_LSB] == 3'h7) ? 3'h0
                        : sh_r[BSI_ADDR_MSB:BSI_ADDR_LSB];
        end else if (sh_r[7:5] == BSI_CMD_CONV_HI[3:1] &&
                     sh_r[3:0] != 4'hE && !sh_r[0] &&
                     sh_r[3:1] <= BSI_RATIO_MAX) begin
          conv_start_r <= 1'b1;
          conv_temp_r  <= sh_r[BSI_TYP_BIT];
          conv_ratio_r <= sh_r[3:1];
          res_valid_r  <= 1'b0;
          mode_r       <= BSI_LAST_CONV;
        end else if (sh_r == BSI_CMD_RESULT) begin
          spoil_r <= busy_w;
          mode_r  <= BSI_LAST_CONV;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // conversion engine
  // busy until done
  bsi_conv #(.BASE_CYC(CONV_CYC)) u_conv (
    .clk                    (clk_sys),
    .rst_n                  (rst_n),
    .start                  (conv_start_r),
    .sel_temp               (conv_temp_r),
    .oversampling_ratio     (conv_ratio_r),
    .spoil                  (spoil_r),
    .raw_pressure_sample    (raw_pressure_sample),
    .raw_temperature_sample (raw_temperature_sample),
    .busy                   (busy_w),
    .done                   (conv_done),
    .result                 (conv_result)
  );
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      conv_busy <= 1'b0;
    else
      conv_busy <= busy_w;
  end
endmodule

//--- testbench/bsi_properties.sv
// Purpose: port checks of the sensor command port
// Assumes: one clock domain, scl and sda seen raw
// Notes:   counters hold the long spans
`timescale 1ns/100ps
module bsi_properties #(
  parameter int CONV_CYC = 16
) (
  input wire logic clk_sys,  // system clock
  input wire logic nrst,     // async reset
  input wire logic scl,      // serial clock
  input wire logic sda_i,    // wire level
  input wire logic sda_o,    // drive value
  input wire logic sda_oe,   // drive enable
  input wire logic conv_busy // converting
);
  // restart while busy may stretch the run, so allow three spans
  localparam int BUSY_MAX = CONV_CYC * 96;
  logic [4:0]  idle_r;
  logic [11:0] busy_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  //////////////////////////////
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) idle_r <= '0;
    else if (!(scl && sda_i)) idle_r <= '0;
    else if (idle_r != 5'h1f) idle_r <= idle_r + 5'h01;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) busy_r <= '0;
    else if (!conv_busy) busy_r <= '0;
    else if (busy_r != 12'hfff) busy_r <= busy_r + 12'h001;
  end
  //////////////////////////////
  a_drive_low: assert property (sda_oe |-> !sda_o)
    else $error("sda driven to a high level");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl)
    else $error("sda drive changed while scl high");
  a_hold_drive: assert property ($rose(sda_oe) |-> sda_oe [*6])
    else $error("sda drive shorter than a bit");
  a_start_release: assert property
    (scl && $fell(sda_i) |-> !sda_oe [*6])
    else $error("device drives right after a start");
  a_idle_quiet: assert property (idle_r > 5'h0f |-> !sda_oe)
    else $error("device drives an idle bus");
  a_busy_min: assert property ($rose(conv_busy) |-> conv_busy [*3])
    else $error("conversion ended at once");
  a_busy_max: assert property (busy_r <= BUSY_MAX)
    else $error("conversion never ended");
  a_reset_quiet: assert property
    ($rose(nrst) |-> (!sda_oe && !conv_busy) [*3])
    else $error("activity right after reset");
  c_busy: cover property ($rose(conv_busy));
  c_drive: cover property ($rose(sda_oe));
  c_done: cover property ($fell(conv_busy));
endmodule

bind bsi_top bsi_properties #(.CONV_CYC(CONV_CYC)) u_bsi_properties (
  .clk_sys(clk_sys), .nrst(nrst), .scl(scl), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .conv_busy(conv_busy));

//--- testbench/bsi_master.sv
// Purpose: serial bus master driving the command port
// Assumes: open-drain sda, pull-up resolved by the bench
// Notes:   scl rests high between frames
`timescale 1ns/100ps
module bsi_master (
  input  wire logic lclk,  // link timebase, 48 ns
  input  wire logic sda_w, // resolved sda level
  output logic      scl,   // serial clock
  output logic      pull   // high pulls sda low
);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  //////////////////////////////
  // framing per transaction
  task automatic start();
    @(negedge lclk) pull = 1'b1;
    @(posedge lclk) scl = 1'b0;
  endtask
  task automatic stop();
    @(negedge lclk) pull = 1'b1;
    @(posedge lclk) scl = 1'b1;
    @(negedge lclk) pull = 1'b0;
  endtask
  // sda only moves in the middle of scl low
  task automatic bit_out(input logic b);
    @(negedge lclk) pull = !b;
    @(posedge lclk) scl = 1'b1;
    @(posedge lclk) scl = 1'b0;
  endtask
  task automatic bit_in(output logic b);
    @(negedge lclk) pull = 1'b0;
    @(posedge lclk) scl = 1'b1;
    @(negedge lclk) b = sda_w;
    @(posedge lclk) scl = 1'b0;
  endtask
  // address byte sent msb first like any byte
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(b);
    ack = !b;
  endtask
  // ack each byte, nack the last
  task automatic rbyte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(!ack);
  endtask
endmodule

//--- testbench/tb.sv
// Purpose: self-checking bench of the sensor command port
// Assumes: master model on the bus, pull-up on sda
// Notes:   short conversion span for a quick run
`timescale 1ns/100ps
module tb;
  import bsi_pkg::*;
  localparam int CONV_CYC = 16;
  localparam logic [15:0] CW [8] = '{16'hf5a3, 16'h8e21, 16'h7c04,
    16'h1b3d, 16'ha0ff, 16'h3691, 16'h6d2e, 16'h0000};
  logic        clk_sys, clk_link, nrst, scl, pull, sda_w;
  logic        sda_o, sda_oe, conv_busy, seen_busy;
  logic [23:0] p_smp, t_smp, rd_val;
  logic [6:0]  bad_ad;
  int          n_mismatch, n_checks, seed;
  assign sda_w = !(sda_oe && !sda_o) && !pull;
  bsi_top #(.CONV_CYC(CONV_CYC), .CAL_W0(CW[0]), .CAL_W1(CW[1]),
    .CAL_W2(CW[2]), .CAL_W3(CW[3]), .CAL_W4(CW[4]), .CAL_W5(CW[5]),
    .CAL_W6(CW[6])) u_bsi_top (.clk_sys(clk_sys), .nrst(nrst),
    .scl(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .raw_pressure_sample(p_smp), .raw_temperature_sample(t_smp),
    .conv_busy(conv_busy));
  bsi_master u_bsi_master (.lclk(clk_link), .sda_w(sda_w), .scl(scl),
    .pull(pull));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #5;
    forever #24 clk_link = ~clk_link;
  end
  always @(posedge conv_busy) seen_busy = 1'b1;
  //////////////////////////////
  // crc over masked word zero and a zero word
  function automatic logic [3:0] crc4();
    logic [15:0] rem;
    logic [15:0] w;
    rem = 16'h0000;
    for (int c = 0; c < 16; c++) begin
      w = (c < 2) ? (CW[0] & 16'h0fff) : CW[c >> 1];
      rem ^= (c % 2 == 1) ? {8'h00, w[7:0]} : {8'h00, w[15:8]};
      for (int b = 0; b < 8; b++)
        rem = rem[15] ? ((rem << 1) ^ 16'h3000) : (rem << 1);
    end
    return rem[15:12];
  endfunction
  function automatic logic [15:0] cal_exp(input logic [2:0] a);
    if (a == 3'h0 || a == 3'h7) return {crc4(), CW[0][11:0]};
    return CW[a];
  endfunction
  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wcmd(input logic [6:0] ad, input logic [7:0] cmd,
                      input logic exp_ack);
    logic a;
    u_bsi_master.start();
    u_bsi_master.wbyte({ad, 1'b0}, a);
    chk1(a, exp_ack);
    if (a) begin
      u_bsi_master.wbyte(cmd, a);
      chk1(a, 1'b1);
    end
    u_bsi_master.stop();
  endtask
  task automatic rd_n(input int n);
    logic       a;
    logic [7:0] b;
    rd_val = '0;
    u_bsi_master.start();
    u_bsi_master.wbyte({BSI_SLAVE_ADDR, 1'b1}, a);
    chk1(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_bsi_master.rbyte(i < n - 1, b);
      rd_val = {rd_val[15:0], b};
    end
    u_bsi_master.stop();
  endtask
  task automatic conv(input logic typ, input logic [2:0] ratio);
    @(negedge clk_sys);
    p_smp = 24'($random(seed));
    t_smp = 24'($random(seed));
    seen_busy = 1'b0;
    wcmd(BSI_SLAVE_ADDR, {3'b010, typ, ratio, 1'b0}, 1'b1);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 2000 && conv_busy !== 1'b0; i++)
      @(posedge clk_sys);
    chk1(conv_busy, 1'b0);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  //////////////////////////////
  initial begin
    #700_000;
    n_mismatch++;
    final_report();
  end
  initial begin
    seed = 32'h1f89_6aa3;
    {n_mismatch, n_checks} = '0;
    {nrst, seen_busy, p_smp, t_smp} = '0;
    repeat (5) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (6) @(negedge clk_sys);
    // calibration first, address seven folds to word zero
    for (int a = 0; a < 8; a++) begin
      wcmd(BSI_SLAVE_ADDR, {4'ha, a[2:0], 1'b0}, 1'b1);
      rd_n(2);
      chk24(rd_val, {8'h00, cal_exp(a[2:0])});
    end
    $display("test calibration done");
    wcmd(BSI_SLAVE_ADDR, BSI_CMD_RESULT, 1'b1);
    rd_n(3);
    chk24(rd_val, 24'h00_0000);
    $display("test early read done");
    for (int k = 0; k < 12; k++) begin
      conv(k >= 6, 3'(k % 6));
      chk1(seen_busy, 1'b1);
      wait_idle();
      wcmd(BSI_SLAVE_ADDR, BSI_CMD_RESULT, 1'b1);
      rd_n(3);
      chk24(rd_val, (k >= 6) ? t_smp : p_smp);
      wcmd(BSI_SLAVE_ADDR, BSI_CMD_RESULT, 1'b1);
      rd_n(3);
      chk24(rd_val, 24'h00_0000);
    end
    $display("test conversions done");
    conv(1'b0, 3'h5);
    wcmd(BSI_SLAVE_ADDR, BSI_CMD_RESULT, 1'b1);
    rd_n(3);
    chk24(rd_val, 24'h00_0000);
    wait_idle();
    wcmd(BSI_SLAVE_ADDR, BSI_CMD_RESULT, 1'b1);
    rd_n(3);
    chk24(rd_val, ~p_smp);
    conv(1'b1, 3'h5);
    conv(1'b1, 3'h5);
    wait_idle();
    wcmd(BSI_SLAVE_ADDR, BSI_CMD_RESULT, 1'b1);
    rd_n(3);
    chk24(rd_val, ~t_smp);
    $display("test spoiled conversions done");
    seen_busy = 1'b0;
    for (int j = 0; j < 4; j++) begin
      bad_ad = (j == 0) ? 7'h77 : 7'($random(seed));
      if (bad_ad == BSI_SLAVE_ADDR) bad_ad = 7'h36;
      wcmd(bad_ad, 8'h48, 1'b0);
    end
    chk1(seen_busy, 1'b0);
    $display("test foreign address done");
    final_report();
  end
endmodule
